// ==== include/ebu_pkg.sv ====
// package of the external bus unit: modes, window config layouts, timing fields
// assumes a 16-bit cpu side issuing one request at a time
package ebu_pkg;
	localparam int NWIN = 4;
	localparam int NCS = 5;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] ALE_MIN = 4'h1;
	localparam logic [1:0] DEF_SEL = 2'h0;
	localparam logic [CNT_W-1:0] RST_CNT = 4'h0;
	localparam logic [NCS-1:0] CS_IDLE = 5'h1f;

	typedef enum logic [2:0] {
		EBU_SINGLE, EBU_DEMUX16, EBU_MUX16, EBU_MUX8, EBU_DEMUX8
	} ebu_mode_t;

	// address space: 16M / 1M / 256K / 64K, giving 8/4/2/0 segment lines
	typedef enum logic [1:0] {EBU_SPC16M, EBU_SPC1M, EBU_SPC256K, EBU_SPC64K} ebu_space_t;

	typedef struct packed {
		logic enable;
		ebu_mode_t mode;
		logic [CNT_W-1:0] cycle_wait;
		logic [CNT_W-1:0] tristate_wait;
		logic [CNT_W-1:0] ale_len;
		logic rw_delay;
		logic ready_en;
		logic ready_polarity;
	} ebu_bcfg_t;

	// window matches when address bits selected by mask equal base under the same mask
	typedef struct packed {
		logic [23:0] base;
		logic [23:0] mask;
	} ebu_asel_t;

	typedef struct packed {
		logic req;
		logic wr;
		logic [23:0] addr;
		logic [15:0] wdata;
	} ebu_req_t;
endpackage

// ==== logic/ebu_window_match.sv ====
// one address window comparator
// assumes base and mask from the window_address_select register
`timescale 1ns/1ps
module ebu_window_match (
	input wire logic [23:0] addr,
	input wire ebu_pkg::ebu_asel_t sel,
	input wire logic en,
	output logic hit
);
	import ebu_pkg::*;
	assign hit = en && ((addr & sel.mask) == (sel.base & sel.mask));
endmodule // ebu_window_match

// ==== logic/ebu_external_bus_unit.sv ====
// external_bus_unit: bus cycle engine, window decode, chip selects, hold arbitration
// assumes req held until done; ready/hold/ack pins asynchronous
//
// Notes on behaviour
// - single-chip plus four mux/demux width modes
// - demux: address on address port, data port
// - mux: address then data on data port
// - cycle, tristate, ale length, rw delay programmable
// - four windows, each select plus config pair
// - window four beats three, two beats one
// - unmatched accesses use default bus config
// - five active-low chip selects, windows plus default
// - ready-enabled window cycles end on active ready
// - arbitration enable hands pins to arbiter
// - master after reset; direction bit selects slave
// - segment lines 8/4/2/0 by address space
// - chip select half cycle late unless timing bit
`timescale 1ns/1ps
module ebu_external_bus_unit (
	input wire logic clk,
	input wire logic rst,
	input wire ebu_pkg::ebu_req_t cpu_req,
	output logic cpu_done,
	output logic [15:0] cpu_rdata,
	input wire ebu_pkg::ebu_bcfg_t default_bus_config,
	input wire ebu_pkg::ebu_bcfg_t [3:0] window_bus_config,
	input wire ebu_pkg::ebu_asel_t [3:0] window_address_select,
	input wire ebu_pkg::ebu_space_t space,
	input wire logic chip_select_timing_cfg,
	input wire logic arbitration_enable,
	input wire logic slave_select_direction_bit,
	input wire logic [15:0] data_port_in,
	output logic [15:0] data_port_out,
	output logic [15:0] data_port_oe,
	output logic [15:0] address_port,
	output logic address_port_oe,
	output logic [7:0] segment_addr,
	output logic ale,
	output logic rd_n,
	output logic wr_n,
	output logic [4:0] chip_select_lines_n,
	input wire logic ready_in,
	input wire logic hold_in,
	output logic hold_acknowledge_out,
	output logic hold_acknowledge_oe,
	input wire logic hold_acknowledge_in,
	output logic bus_request_out
);
	import ebu_pkg::*;
	typedef enum logic [2:0] {S_IDLE, S_ALE, S_DLY, S_CMD, S_TRI, S_HELD} ebu_st_t;
	ebu_st_t st_r;
	logic [CNT_W-1:0] cnt_r;
	logic [NWIN-1:0] hit;
	ebu_bcfg_t cfg_r, sel_cfg;
	logic [2:0] cs_idx, cs_idx_r;
	logic cs_half_r;
	logic [1:0] rdy_s, hold_s, hold_acknowledge_s;
	logic rdy_ok, hold_sync, slave_r, mux, bit8, wr_r, granted;

	// comparators per window
	for (genvar g = 0; g < NWIN; g++) begin : g_win
		ebu_window_match u_match (
			.addr(cpu_req.addr),
			.sel(window_address_select[g]),
			.en(window_bus_config[g].enable),
			.hit(hit[g])
		);
	end

	// priority: 4 over 3, 2 over 1; pair 4/3 ahead of 2/1
	always_comb begin
		sel_cfg = default_bus_config;
		cs_idx = 3'h0;
		if (hit[3]) begin
			sel_cfg = window_bus_config[3];
			cs_idx = 3'h4;
		end else if (hit[2]) begin
			sel_cfg = window_bus_config[2];
			cs_idx = 3'h3;
		end else if (hit[1]) begin
			sel_cfg = window_bus_config[1];
			cs_idx = 3'h2;
		end else if (hit[0]) begin
			sel_cfg = window_bus_config[0];
			cs_idx = 3'h1;
		end
	end

	// pin synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			rdy_s <= 2'h0;
			hold_s <= 2'h0;
			hold_acknowledge_s <= 2'h0;
		end else begin
			rdy_s <= {rdy_s[0], ready_in};
			hold_s <= {hold_s[0], hold_in};
			hold_acknowledge_s <= {hold_acknowledge_s[0], hold_acknowledge_in};
		end
	end
	assign rdy_ok = !cfg_r.ready_en || (rdy_s[1] == cfg_r.ready_polarity);
	assign hold_sync = arbitration_enable && !slave_r && hold_s[1];
	assign mux = (cfg_r.mode == EBU_MUX16) || (cfg_r.mode == EBU_MUX8);
	assign bit8 = (cfg_r.mode == EBU_MUX8) || (cfg_r.mode == EBU_DEMUX8);
	// slave may start only once the master's acknowledge (active low) is seen
	assign granted = !(arbitration_enable && slave_r && hold_acknowledge_s[1]);

	always_ff @(posedge clk) begin
		if (rst) slave_r <= 1'b0;
		else slave_r <= slave_select_direction_bit;
	end

	// cycle engine
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= S_IDLE;
			cnt_r <= RST_CNT;
			cfg_r <= '0;
			cs_idx_r <= 3'h0;
			wr_r <= 1'b0;
			cpu_done <= 1'b0;
			cpu_rdata <= 16'h0000;
		end else begin
			cpu_done <= 1'b0;
			case (st_r)
				S_IDLE: if (hold_sync) begin
					st_r <= S_HELD;
				end else if (cpu_req.req && !cpu_done && granted) begin
					if (sel_cfg.mode == EBU_SINGLE || !sel_cfg.enable) begin
						cpu_done <= 1'b1;
						cpu_rdata <= 16'h0000;
					end else begin
						cfg_r <= sel_cfg;
						cs_idx_r <= cs_idx;
						wr_r <= cpu_req.wr;
						cnt_r <= (sel_cfg.ale_len < ALE_MIN) ? ALE_MIN : sel_cfg.ale_len;
						st_r <= S_ALE;
					end
				end
				S_ALE: if (cnt_r <= ALE_MIN) begin
					st_r <= cfg_r.rw_delay ? S_DLY : S_CMD;
					cnt_r <= cfg_r.cycle_wait;
				end else cnt_r <= cnt_r - 4'h1;
				S_DLY: st_r <= S_CMD;
				S_CMD: if (cnt_r != RST_CNT) cnt_r <= cnt_r - 4'h1;
				else if (rdy_ok) begin
					cpu_rdata <= bit8 ? {8'h00, data_port_in[7:0]} : data_port_in;
					cpu_done <= 1'b1;
					cnt_r <= cfg_r.tristate_wait;
					st_r <= S_TRI;
				end
				S_TRI: if (cnt_r != RST_CNT) cnt_r <= cnt_r - 4'h1;
				else st_r <= S_IDLE;
				S_HELD: if (!hold_sync) st_r <= S_IDLE;
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// pins
	always_ff @(posedge clk) begin
		if (rst) begin
			data_port_out <= 16'h0000;
			data_port_oe <= 16'h0000;
			address_port <= 16'h0000;
			address_port_oe <= 1'b0;
			segment_addr <= 8'h00;
			ale <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
		end else begin
			ale <= (st_r == S_ALE);
			// strobes held back through the delay state
			rd_n <= !((st_r == S_CMD) && !wr_r);
			wr_n <= !((st_r == S_CMD) && wr_r);
			address_port_oe <= (st_r != S_HELD) && (st_r != S_IDLE) && !mux;
			address_port <= cpu_req.addr[15:0];
			case (space)
				EBU_SPC16M: segment_addr <= cpu_req.addr[23:16];
				EBU_SPC1M: segment_addr <= {4'h0, cpu_req.addr[19:16]};
				EBU_SPC256K: segment_addr <= {6'h00, cpu_req.addr[17:16]};
				default: segment_addr <= 8'h00;
			endcase
			if (st_r == S_ALE && mux) begin
				data_port_out <= cpu_req.addr[15:0];
				data_port_oe <= 16'hffff;
			end else if ((st_r == S_CMD || st_r == S_DLY) && wr_r) begin
				data_port_out <= cpu_req.wdata;
				data_port_oe <= bit8 ? 16'h00ff : 16'hffff;
			end else begin
				data_port_oe <= 16'h0000;
			end
		end
	end

	// chip selects: late by half cycle modelled as one extra flop stage
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_half_r <= 1'b0;
			chip_select_lines_n <= CS_IDLE;
		end else begin
			cs_half_r <= (st_r == S_ALE) || (st_r == S_DLY) || (st_r == S_CMD);
			if (chip_select_timing_cfg ? (st_r == S_ALE || st_r == S_DLY || st_r == S_CMD)
				: cs_half_r) begin
				chip_select_lines_n <= ~(5'h01 << cs_idx_r);
			end else chip_select_lines_n <= CS_IDLE;
		end
	end

	// arbitration pins
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_acknowledge_out <= 1'b1;
			hold_acknowledge_oe <= 1'b0;
			bus_request_out <= 1'b0;
		end else begin
			hold_acknowledge_oe <= arbitration_enable && !slave_r;
			hold_acknowledge_out <= !(st_r == S_HELD);
			bus_request_out <= arbitration_enable && slave_r && cpu_req.req;
		end
	end

	property p_cs_one;
		@(posedge clk) disable iff (rst) $countones(~chip_select_lines_n) <= 1;
	endproperty
	a_cs_one: assert property (p_cs_one) else $error("two chip selects");
	property p_held_float;
		@(posedge clk) disable iff (rst) st_r == S_HELD |=> !address_port_oe && data_port_oe == 16'h0;
	endproperty
	a_held_float: assert property (p_held_float) else $error("bus driven in hold");
	property p_rdy;
		@(posedge clk) disable iff (rst) st_r == S_CMD && !rdy_ok |=> st_r == S_CMD;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ended without ready");
	property p_prio;
		@(posedge clk) disable iff (rst) hit[3] |-> cs_idx == 3'h4;
	endproperty
	a_prio: assert property (p_prio) else $error("window four lost");
	property p_def;
		@(posedge clk) disable iff (rst) hit == 4'h0 |-> sel_cfg == default_bus_config;
	endproperty
	a_def: assert property (p_def) else $error("default config not used");
	property p_seg;
		@(posedge clk) disable iff (rst) space == EBU_SPC64K |=> segment_addr == 8'h00;
	endproperty
	a_seg: assert property (p_seg) else $error("segment lines on 64k");
	property p_mux;
		@(posedge clk) disable iff (rst) st_r == S_ALE && mux |=> data_port_oe == 16'hffff;
	endproperty
	a_mux: assert property (p_mux) else $error("mux address not driven");
	property p_hold_acknowledge;
		@(posedge clk) disable iff (rst) slave_r |=> !hold_acknowledge_oe;
	endproperty
	a_hold_acknowledge: assert property (p_hold_acknowledge) else $error("slave drives ack");
	property p_cs_time;
		@(posedge clk) disable iff (rst)
			$rose(ale) |-> (chip_select_lines_n != CS_IDLE) == chip_select_timing_cfg;
	endproperty
	a_cs_time: assert property (p_cs_time) else $error("chip select timing wrong");
	property p_bus_request_out;
		@(posedge clk) disable iff (rst) !arbitration_enable |=> !bus_request_out;
	endproperty
	a_bus_request_out: assert property (p_bus_request_out) else $error("request without arbitration");
	c_cs_early: cover property (@(posedge clk) $rose(ale) && chip_select_timing_cfg);
	c_held: cover property (@(posedge clk) st_r == S_HELD);
	c_done: cover property (@(posedge clk) cpu_done && cfg_r.ready_en);
	c_mux: cover property (@(posedge clk) st_r == S_ALE && mux);
endmodule // ebu_external_bus_unit

// ==== dv/ebu_ext_mem.sv ====
// external memory model: 16-word store, programmable ready latency
// assumes address latched while ale is high, from address port or data port
`timescale 1ns/1ps
module ebu_ext_mem (
	input wire logic clk,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [15:0] address_port,
	input wire logic address_port_oe,
	input wire logic [15:0] data_port_out,
	input wire logic ready_pol,
	input wire logic [3:0] ready_lat,
	output logic [15:0] data_port_in,
	output logic ready_in
);
	logic [15:0] mem [16];
	logic [15:0] last = 16'h0;
	logic [3:0] addr_l = 4'h0;
	logic [3:0] cnt = 4'h0;
	logic cmd;
	assign cmd = !rd_n || !wr_n;
	assign ready_in = (cmd && cnt >= ready_lat) ? ready_pol : !ready_pol;
	// released lines show the inverse of the last value
	assign data_port_in = !rd_n ? mem[addr_l] : ~last;
	always @(posedge clk) begin
		last <= data_port_in;
		if (ale)
			addr_l <= address_port_oe ? address_port[3:0] : data_port_out[3:0];
		if (!cmd)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
		if (!wr_n && ready_in == ready_pol)
			mem[addr_l] <= data_port_out;
	end
endmodule // ebu_ext_mem

// ==== dv/tb_top.sv ====
// testbench of the external bus unit: cpu-side accesses, window decode, hold
// assumes the memory model on the far side and one access at a time
`timescale 1ns/1ps
module tb_top;
	import ebu_pkg::*;
	logic clk, rst, cpu_done, ale, rd_n, wr_n, address_port_oe, hold_in;
	logic hold_acknowledge_out, hold_acknowledge_oe, ready_in, ready_pol;
	logic bus_request_out, hold_ack_in, ale_q;
	logic chip_select_timing_cfg, arbitration_enable, slave_select_direction_bit;
	logic [15:0] cpu_rdata, data_port_in, data_port_out, data_port_oe, address_port, q;
	logic [7:0] segment_addr, seg_seen;
	logic [4:0] chip_select_lines_n, cs_acc, cs_rise;
	logic [3:0] ready_lat;
	ebu_req_t cpu_req;
	ebu_bcfg_t dcfg;
	ebu_bcfg_t [3:0] wcfg;
	ebu_asel_t [3:0] wsel;
	ebu_space_t space;
	int err_count, cmp_count, n, n0;

	ebu_external_bus_unit ebu_external_bus_unit_i (.clk(clk), .rst(rst), .cpu_req(cpu_req),
		.cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .default_bus_config(dcfg),
		.window_bus_config(wcfg), .window_address_select(wsel), .space(space),
		.chip_select_timing_cfg(chip_select_timing_cfg),
		.arbitration_enable(arbitration_enable),
		.slave_select_direction_bit(slave_select_direction_bit),
		.data_port_in(data_port_in), .data_port_out(data_port_out),
		.data_port_oe(data_port_oe), .address_port(address_port),
		.address_port_oe(address_port_oe), .segment_addr(segment_addr), .ale(ale),
		.rd_n(rd_n), .wr_n(wr_n), .chip_select_lines_n(chip_select_lines_n),
		.ready_in(ready_in), .hold_in(hold_in), .hold_acknowledge_out(hold_acknowledge_out),
		.hold_acknowledge_oe(hold_acknowledge_oe), .hold_acknowledge_in(hold_ack_in),
		.bus_request_out(bus_request_out));
	ebu_ext_mem ebu_ext_mem_i (.clk(clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
		.address_port(address_port), .address_port_oe(address_port_oe),
		.data_port_out(data_port_out), .ready_pol(ready_pol), .ready_lat(ready_lat),
		.data_port_in(data_port_in), .ready_in(ready_in));

	function automatic ebu_bcfg_t mk(ebu_mode_t m, logic [3:0] cw, logic [3:0] al,
		logic rwd, logic ren);
		return '{1'b1, m, cw, 4'h1, al, rwd, ren, 1'b0};
	endfunction
	task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run();
		if (err_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic acc(logic w, logic [23:0] a, logic [15:0] d);
		@(posedge clk);
		cpu_req <= '{1'b1, w, a, d};
		#1 cs_acc = 5'h00;
		for (n = 1; n < 300; n++) begin
			@(posedge clk);
			if (cpu_done === 1'b1)
				break;
		end
		q = cpu_rdata;
		cpu_req.req <= 1'b0;
		if (n == 300) begin
			chk("done_timeout", 24'h1, 24'h0);
			complete_run();
		end
		repeat (20) @(posedge clk);
	endtask
	task automatic wait_ack(logic lvl);
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			#1;
			if (hold_acknowledge_out === lvl)
				break;
		end
		chk("ack_wait", 24'h1, 24'(n < 40));
		if (n == 40)
			complete_run();
	endtask

	// cs and segment lines seen while a cycle runs
	always @(posedge clk) begin
		cs_acc <= cs_acc | ~chip_select_lines_n;
		ale_q <= ale;
		if (ale === 1'b1 && ale_q === 1'b0)
			cs_rise <= chip_select_lines_n;
		if (chip_select_lines_n !== CS_IDLE)
			seg_seen <= segment_addr;
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{rst, hold_in, ready_pol, chip_select_timing_cfg} = 4'h8;
		{arbitration_enable, slave_select_direction_bit, ready_lat} = 6'h00;
		cpu_req = '0;
		wcfg = '0;
		wsel = '0;
		cs_acc = 5'h00;
		cs_rise = 5'h00;
		seg_seen = 8'h00;
		ale_q = 1'b0;
		hold_ack_in = 1'b1;
		dcfg = mk(EBU_DEMUX16, 4'h1, ALE_MIN, 1'b0, 1'b0);
		space = EBU_SPC16M;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk("cs_idle", 24'(CS_IDLE), 24'(chip_select_lines_n));
		chk("ack_idle", 24'h1, 24'(hold_acknowledge_out));
		acc(1'b1, 24'h120003, 16'h5a3c);
		acc(1'b0, 24'h120003, 16'h0);
		n0 = n;
		chk("demux_rd", 24'h5a3c, 24'(q));
		chk("cs_default", 24'h01, 24'(cs_acc));
		chk("seg_16m", 24'h12, 24'(seg_seen));
		chk("cs_late", 24'(CS_IDLE), 24'(cs_rise));
		dcfg <= mk(EBU_DEMUX16, 4'h5, ALE_MIN, 1'b0, 1'b0);
		acc(1'b0, 24'h120003, 16'h0);
		chk("cycle_wait", 24'(n0 + 4), 24'(n));
		dcfg <= mk(EBU_DEMUX16, 4'h1, ALE_MIN + 4'h2, 1'b0, 1'b0);
		acc(1'b0, 24'h120003, 16'h0);
		chk("ale_len", 24'(n0 + 2), 24'(n));
		dcfg <= mk(EBU_DEMUX16, 4'h1, ALE_MIN, 1'b1, 1'b0);
		acc(1'b0, 24'h120003, 16'h0);
		chk("rw_delay", 24'(n0 + 1), 24'(n));
		dcfg <= mk(EBU_DEMUX16, 4'h1, ALE_MIN, 1'b0, 1'b0);
		wsel <= {{2{48'h300000_f00000}}, {2{48'h200000_f00000}}};
		wcfg <= {mk(EBU_MUX8, 4'h1, ALE_MIN, 1'b0, 1'b1), mk(EBU_DEMUX16, 4'h1, ALE_MIN,
			1'b0, 1'b0), mk(EBU_MUX16, 4'h1, ALE_MIN, 1'b0, 1'b0), dcfg};
		acc(1'b1, 24'h200005, 16'h1234);
		chk("cs_win2", 24'h04, 24'(cs_acc));
		acc(1'b0, 24'h200005, 16'h0);
		chk("mux16_rd", 24'h1234, 24'(q));
		acc(1'b1, 24'h300006, 16'hbeef);
		chk("cs_win4", 24'h10, 24'(cs_acc));
		acc(1'b0, 24'h300006, 16'h0);
		n0 = n;
		chk("mux8_rd", 24'h00ef, 24'(q));
		ready_lat <= 4'h6;
		acc(1'b0, 24'h300006, 16'h0);
		chk("ready_wait", 24'(n0 + 6), 24'(n));
		wcfg[1].enable <= 1'b0;
		acc(1'b0, 24'h200005, 16'h0);
		chk("cs_win1", 24'h02, 24'(cs_acc));
		space <= EBU_SPC64K;
		acc(1'b0, 24'h120003, 16'h0);
		chk("seg_64k", 24'h00, 24'(seg_seen));
		space <= EBU_SPC1M;
		acc(1'b0, 24'h120003, 16'h0);
		chk("seg_1m", 24'h02, 24'(seg_seen));
		dcfg <= mk(EBU_SINGLE, 4'h1, ALE_MIN, 1'b0, 1'b0);
		acc(1'b0, 24'h120003, 16'h0);
		chk("single_cs", 24'h00, 24'(cs_acc));
		chk("single_fast", 24'h1, 24'(n <= 3));
		dcfg <= mk(EBU_DEMUX16, 4'h1, ALE_MIN, 1'b0, 1'b0);
		chip_select_timing_cfg <= 1'b1;
		acc(1'b0, 24'h120003, 16'h0);
		chk("cs_early", 24'h1e, 24'(cs_rise));
		chk("early_rd", 24'h5a3c, 24'(q));
		arbitration_enable <= 1'b1;
		hold_in <= 1'b1;
		wait_ack(1'b0);
		chk("ack_oe", 24'h1, 24'(hold_acknowledge_oe));
		chk("float", 24'h0, 24'({address_port_oe, data_port_oe}));
		@(posedge clk);
		cpu_req <= '{1'b1, 1'b0, 24'h120003, 16'h0};
		#1 cs_acc = 5'h00;
		repeat (10) @(posedge clk);
		chk("held_cs", 24'h0, 24'(cs_acc));
		hold_in <= 1'b0;
		wait_ack(1'b1);
		acc(1'b0, 24'h120003, 16'h0);
		chk("reclaim_rd", 24'h5a3c, 24'(q));
		slave_select_direction_bit <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("slave_oe", 24'h0, 24'(hold_acknowledge_oe));
		@(posedge clk);
		cpu_req <= '{1'b1, 1'b0, 24'h120003, 16'h0};
		#1 cs_acc = 5'h00;
		repeat (10) @(posedge clk);
		#1 chk("slave_bus_request_out", 24'h1, 24'(bus_request_out));
		chk("slave_wait_cs", 24'h0, 24'(cs_acc));
		@(posedge clk);
		hold_ack_in <= 1'b0;
		acc(1'b0, 24'h120003, 16'h0);
		chk("slave_rd", 24'h5a3c, 24'(q));
		chk("bus_request_out_drop", 24'h0, 24'(bus_request_out));
		complete_run();
	end
endmodule // tb_top
